/* src/sdrbs_pkg.sv */
// sdrbs_pkg: constants, command codes, bank states and carrier structs for the
// sdram refresh / bank-state block.
// assumes a 125 MHz core_clk; all timing figures become cycle counts here.
package sdrbs_pkg;

  localparam int CLK_PERIOD_PS = 8000;

  // timing figures in picoseconds, counts derived (least times round up)
  localparam int PRECHARGE_PERIOD_PS          = 20000;
  localparam int REFRESH_CYCLE_TIME_PS        = 66000;
  localparam int ACTIVATE_TO_ACCESS_DELAY_PS  = 20000;
  localparam int SELF_REFRESH_EXIT_TIME_PS    = 67000;
  localparam int MIN_ROW_ACTIVE_TIME_PS       = 44000;
  localparam int MODE_LOAD_DELAY_PS           = 16000;
  localparam int BURST_LENGTH_CYCLES          = 4;
  // internal self-refresh interval: 7.813 us, longest time rounds down
  localparam int SELF_REFRESH_INTERVAL_PS     = 7813000;

  function automatic int cyc_up(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up

  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] PRECHARGE_CYC = CNT_W'(cyc_up(PRECHARGE_PERIOD_PS));
  localparam logic [CNT_W-1:0] REFRESH_CYC   = CNT_W'(cyc_up(REFRESH_CYCLE_TIME_PS));
  localparam logic [CNT_W-1:0] ACTIVATE_CYC  = CNT_W'(cyc_up(ACTIVATE_TO_ACCESS_DELAY_PS));
  localparam logic [CNT_W-1:0] SR_EXIT_CYC   = CNT_W'(cyc_up(SELF_REFRESH_EXIT_TIME_PS) < 2 ? 2
                                                      : cyc_up(SELF_REFRESH_EXIT_TIME_PS));
  localparam logic [CNT_W-1:0] ROW_ACTIVE_CYC = CNT_W'(cyc_up(MIN_ROW_ACTIVE_TIME_PS));
  localparam logic [CNT_W-1:0] MODE_LOAD_CYC = CNT_W'(cyc_up(MODE_LOAD_DELAY_PS));
  localparam logic [CNT_W-1:0] BURST_CYC     = CNT_W'(BURST_LENGTH_CYCLES);
  localparam logic [CNT_W-1:0] SR_INTERVAL_CYC = CNT_W'(SELF_REFRESH_INTERVAL_PS / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] CNT_ZERO      = 12'h000;

  localparam int NUM_BANKS = 4;
  localparam int ROW_W     = 13;
  localparam int ADDR_W    = 13;
  localparam int AP_BIT    = 10;
  localparam logic [ROW_W-1:0] ROW_RESET = 13'h0000;

  typedef enum logic [2:0] {
    SDRBS_INHIBIT, SDRBS_NOP, SDRBS_ACTIVATE, SDRBS_REFRESH,
    SDRBS_MODE_LOAD, SDRBS_PRECHARGE, SDRBS_READ, SDRBS_WRITE
  } sdrbs_cmd_type;

  // burst stop shares no code with the others; carried as a flag
  typedef enum logic [3:0] {
    BANK_IDLE, BANK_ACTIVATING, BANK_ROW_ACTIVE, BANK_READ, BANK_WRITE,
    BANK_READ_AP, BANK_WRITE_AP, BANK_PRECHARGING
  } sdrbs_bank_state_type;

  typedef enum logic [2:0] {
    DEV_NORMAL, DEV_REFRESHING, DEV_MODE_LOAD, DEV_PRECHARGE_ALL,
    DEV_SELF_REFRESH, DEV_SR_EXIT
  } sdrbs_dev_state_type;

  // command pins as sampled
  typedef struct packed {
    logic              cke;
    logic              chip_select_n;
    logic              row_strobe_n;
    logic              column_strobe_n;
    logic              write_enable_n;
    logic              bank_select_high;
    logic              bank_select_low;
    logic [ADDR_W-1:0] addr;
  } sdrbs_pins_type;

  // decoded command handed to each bank
  typedef struct packed {
    logic valid;
    logic activate;
    logic read;
    logic write;
    logic precharge;
    logic burst_stop;
    logic auto_precharge_select_bit;
  } sdrbs_bank_cmd_type;

endpackage : sdrbs_pkg

/* src/sdrbs_sync.sv */
// sdrbs_sync: three-stage synchroniser with agreement of the last two stages.
// assumes the input is asynchronous to core_clk.
`timescale 1ns/1ns
module sdrbs_sync #(
  parameter int          WIDTH = 1,
  parameter logic [31:0] INIT  = 32'h0000_0000
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             srst,
  // data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1, s2, s3;
  logic [WIDTH-1:0] next_s1, next_s2, next_s3, next_dout;

  always_comb begin
    next_s1 = din;
    next_s2 = s1;
    next_s3 = s2;
    // a bit changes only once stages two and three agree
    for (int i = 0; i < WIDTH; i++) begin
      next_dout[i] = (s2[i] == s3[i]) ? s3[i] : dout[i];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s1   <= INIT[WIDTH-1:0];
      s2   <= INIT[WIDTH-1:0];
      s3   <= INIT[WIDTH-1:0];
      dout <= INIT[WIDTH-1:0];
    end else begin
      s1   <= next_s1;
      s2   <= next_s2;
      s3   <= next_s3;
      dout <= next_dout;
    end
  end
endmodule : sdrbs_sync

/* src/sdrbs_bank.sv */
// sdrbs_bank: state register and down-counter for one bank.
// assumes commands arrive already decoded and gated by the device state.
`timescale 1ns/1ns
module sdrbs_bank (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        srst,
  // command to this bank, and burst stop when the latest read or write named it
  input  wire sdrbs_pkg::sdrbs_bank_cmd_type cmd,
  input  wire logic                        stop_here,
  // all-bank precharge
  input  wire logic                        precharge_all,
  // state
  output sdrbs_pkg::sdrbs_bank_state_type  state,
  output logic                             illegal
);
  sdrbs_pkg::sdrbs_bank_state_type next_state;
  logic [sdrbs_pkg::CNT_W-1:0]     cnt, next_cnt;
  logic                            next_illegal;
  logic                            busy_ap;

  always_comb begin
    next_state   = state;
    next_cnt     = (cnt != sdrbs_pkg::CNT_ZERO) ? cnt - 1'b1 : cnt;
    next_illegal = 1'b0;
    busy_ap      = (state == sdrbs_pkg::BANK_READ_AP) || (state == sdrbs_pkg::BANK_WRITE_AP);
    unique case (state)
      sdrbs_pkg::BANK_IDLE: begin
        if (cmd.activate) begin
          next_state = sdrbs_pkg::BANK_ACTIVATING;
          next_cnt   = sdrbs_pkg::ACTIVATE_CYC;
        end else if (cmd.read || cmd.write) begin
          next_illegal = 1'b1;
        end
        // precharge to an idle bank acts as a no-op for it
      end
      sdrbs_pkg::BANK_ACTIVATING, sdrbs_pkg::BANK_PRECHARGING,
      sdrbs_pkg::BANK_READ_AP, sdrbs_pkg::BANK_WRITE_AP: begin
        if (cmd.valid) begin
          next_illegal = 1'b1;
        end
        if (next_cnt == sdrbs_pkg::CNT_ZERO) begin
          next_state = (state == sdrbs_pkg::BANK_ACTIVATING) ? sdrbs_pkg::BANK_ROW_ACTIVE
                                                             : sdrbs_pkg::BANK_IDLE;
        end
      end
      default: begin
        // row active, read, write without auto precharge
        if (cmd.read || cmd.write) begin
          next_state = cmd.auto_precharge_select_bit
                     ? (cmd.read ? sdrbs_pkg::BANK_READ_AP : sdrbs_pkg::BANK_WRITE_AP)
                     : (cmd.read ? sdrbs_pkg::BANK_READ : sdrbs_pkg::BANK_WRITE);
          // auto precharge bursts run the burst then the precharge period
          next_cnt   = cmd.auto_precharge_select_bit ? sdrbs_pkg::BURST_CYC + sdrbs_pkg::PRECHARGE_CYC
                                                     : sdrbs_pkg::BURST_CYC;
        end else if (cmd.precharge) begin
          next_state = sdrbs_pkg::BANK_PRECHARGING;
          next_cnt   = sdrbs_pkg::PRECHARGE_CYC;
        end else if (cmd.activate) begin
          next_illegal = 1'b1;
        end else if (stop_here && state != sdrbs_pkg::BANK_ROW_ACTIVE) begin
          next_state = sdrbs_pkg::BANK_ROW_ACTIVE;
          next_cnt   = sdrbs_pkg::CNT_ZERO;
        end else if (state != sdrbs_pkg::BANK_ROW_ACTIVE && next_cnt == sdrbs_pkg::CNT_ZERO) begin
          next_state = sdrbs_pkg::BANK_ROW_ACTIVE;
        end
      end
    endcase
    if (precharge_all && !busy_ap && state != sdrbs_pkg::BANK_ACTIVATING) begin
      next_state = sdrbs_pkg::BANK_IDLE;
      next_cnt   = sdrbs_pkg::CNT_ZERO;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state   <= sdrbs_pkg::BANK_IDLE;
      cnt     <= sdrbs_pkg::CNT_ZERO;
      illegal <= 1'b0;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      illegal <= next_illegal;
    end
  end
endmodule : sdrbs_bank

/* src/sdrbs_top.sv */
// sdrbs_top: command decode, all-bank operations, refresh counter and
// self refresh for a four-bank sdram, one state machine per bank.
// assumes the command pins come from a controller outside core_clk's domain
// and pass the synchroniser; the self-refresh timer runs from core_clk,
// standing in for the device's own oscillator.
`timescale 1ns/1ns

// Summary of operation
// - Auto refresh row comes from the internal counter; address inputs ignored.
// - Self refresh entry is the refresh pattern with clock-enable sampled low.
// - In self refresh only clock-enable matters; controller holds it low.
// - In self refresh the device times and performs refreshes itself.
// - Automotive parts offer no self refresh.
// - Command decode from chip-select, row, column strobe and write enable.
// - Precharge to an idle bank leaves it unchanged, acting as no-op.
// - Refresh and mode load need all banks idle and address no bank.
// - Active or plain-bursting bank accepts reads and writes, starting new burst.
// - Precharge during a plain burst cuts it short and starts precharging.
// - Burst stop ends the latest plain read or write burst in any bank.
// - Activation ends after the access delay; precharges end after precharge period.
// - Refresh, mode load, precharge all take only no-ops, then all idle; precharge all does not idle banks that were activating or auto-precharging.
// - Precharge with auto-precharge bit high precharges all banks not activating or auto-precharging.
// - Read or write with that bit high precharges automatically at burst end.
module sdrbs_top #(
  parameter bit AUTOMOTIVE = 1'b0
) (
  // clock and reset
  input  wire logic                                   core_clk,
  input  wire logic                                   srst,
  // command and address pins from the controller
  input  wire sdrbs_pkg::sdrbs_pins_type              pins,
  // status
  output sdrbs_pkg::sdrbs_bank_state_type             bank_state [sdrbs_pkg::NUM_BANKS],
  output sdrbs_pkg::sdrbs_dev_state_type              dev_state,
  output logic                                        all_idle,
  output logic                                        self_refresh_active,
  // refresh activity and mode load values
  output logic                                        refresh_pulse,
  output logic [sdrbs_pkg::ROW_W-1:0]                 refresh_row,
  output logic [1:0]                                  mode_bank_bits,
  output logic [sdrbs_pkg::ADDR_W-1:0]                mode_opcode,
  // illegal command seen, one-cycle pulse
  output logic                                        illegal_cmd
);
  localparam int PIN_W = $bits(sdrbs_pkg::sdrbs_pins_type);

  sdrbs_pkg::sdrbs_pins_type        sp;
  logic [PIN_W-1:0]                 sp_bits;
  sdrbs_pkg::sdrbs_cmd_type         cmd;
  logic                             burst_stop;
  logic [1:0]                       bank_sel;
  logic                             ap_bit;
  sdrbs_pkg::sdrbs_bank_cmd_type    bank_cmd [sdrbs_pkg::NUM_BANKS];
  logic [sdrbs_pkg::NUM_BANKS-1:0]  stop_here;
  logic [sdrbs_pkg::NUM_BANKS-1:0]  bank_illegal;
  logic [sdrbs_pkg::NUM_BANKS-1:0]  bank_idle;
  logic                             pre_all;
  logic                             normal;

  sdrbs_pkg::sdrbs_dev_state_type   next_dev_state;
  logic [sdrbs_pkg::CNT_W-1:0]      busy_cnt, next_busy_cnt;
  logic [sdrbs_pkg::CNT_W-1:0]      sr_timer, next_sr_timer;
  logic [sdrbs_pkg::ROW_W-1:0]      next_refresh_row;
  logic                             next_refresh_pulse;
  logic [1:0]                       last_bank, next_last_bank;
  logic                             next_illegal_cmd;
  logic [1:0]                       next_mode_bank_bits;
  logic [sdrbs_pkg::ADDR_W-1:0]     next_mode_opcode;
  logic [4:0]                       cmd_pins, last_cmd_pins, next_last_cmd_pins;
  logic                             fresh;

  // pins come from outside the clock domain
  sdrbs_sync #(.WIDTH(PIN_W), .INIT(32'h0000_0000 | (32'h1 << (PIN_W - 2)))) u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .din      (pins),
    .dout     (sp_bits)
  );
  assign sp = sp_bits;

  // a command must stand two cycles to pass the filter, so only its first cycle
  // is taken; the same command twice in a row needs a nop between them
  assign cmd_pins = {sp.cke, sp.chip_select_n, sp.row_strobe_n, sp.column_strobe_n, sp.write_enable_n};
  assign fresh    = (cmd_pins != last_cmd_pins);

  // command decode
  always_comb begin
    burst_stop = 1'b0;
    if (sp.chip_select_n) begin
      cmd = sdrbs_pkg::SDRBS_INHIBIT;
    end else if (!fresh) begin
      cmd = sdrbs_pkg::SDRBS_NOP;
    end else begin
      unique case ({sp.row_strobe_n, sp.column_strobe_n, sp.write_enable_n})
        3'b111:  cmd = sdrbs_pkg::SDRBS_NOP;
        3'b011:  cmd = sdrbs_pkg::SDRBS_ACTIVATE;
        3'b001:  cmd = sdrbs_pkg::SDRBS_REFRESH;
        3'b000:  cmd = sdrbs_pkg::SDRBS_MODE_LOAD;
        3'b010:  cmd = sdrbs_pkg::SDRBS_PRECHARGE;
        3'b101:  cmd = sdrbs_pkg::SDRBS_READ;
        3'b100:  cmd = sdrbs_pkg::SDRBS_WRITE;
        default: begin
          cmd        = sdrbs_pkg::SDRBS_NOP;
          burst_stop = 1'b1;
        end
      endcase
    end
  end

  assign bank_sel = {sp.bank_select_high, sp.bank_select_low};
  assign ap_bit   = sp.addr[sdrbs_pkg::AP_BIT];
  assign normal   = (dev_state == sdrbs_pkg::DEV_NORMAL) && sp.cke;
  assign pre_all  = normal && (cmd == sdrbs_pkg::SDRBS_PRECHARGE) && ap_bit;

  // route bank commands; refresh and mode load address no bank
  always_comb begin
    for (int b = 0; b < sdrbs_pkg::NUM_BANKS; b++) begin
      bank_cmd[b]  = '0;
      stop_here[b] = normal && burst_stop && (last_bank == 2'(b));
      if (normal && bank_sel == 2'(b)) begin
        bank_cmd[b].activate  = (cmd == sdrbs_pkg::SDRBS_ACTIVATE);
        bank_cmd[b].read      = (cmd == sdrbs_pkg::SDRBS_READ);
        bank_cmd[b].write     = (cmd == sdrbs_pkg::SDRBS_WRITE);
        bank_cmd[b].precharge = (cmd == sdrbs_pkg::SDRBS_PRECHARGE) && !ap_bit;
        bank_cmd[b].auto_precharge_select_bit = ap_bit;
        bank_cmd[b].valid     = bank_cmd[b].activate || bank_cmd[b].read ||
                                bank_cmd[b].write || bank_cmd[b].precharge;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < sdrbs_pkg::NUM_BANKS; g++) begin : gen_bank
      sdrbs_bank u_bank (
        .core_clk      (core_clk),
        .srst          (srst),
        .cmd           (bank_cmd[g]),
        .stop_here     (stop_here[g]),
        .precharge_all (pre_all),
        .state         (bank_state[g]),
        .illegal       (bank_illegal[g])
      );
      assign bank_idle[g] = (bank_state[g] == sdrbs_pkg::BANK_IDLE);
    end
  endgenerate

  assign all_idle            = &bank_idle && (dev_state == sdrbs_pkg::DEV_NORMAL);
  assign self_refresh_active = (dev_state == sdrbs_pkg::DEV_SELF_REFRESH);

  // device-wide state: refresh, mode load, precharge all, self refresh
  always_comb begin
    next_dev_state      = dev_state;
    next_busy_cnt       = (busy_cnt != sdrbs_pkg::CNT_ZERO) ? busy_cnt - 1'b1 : busy_cnt;
    next_sr_timer       = sr_timer;
    next_refresh_row    = refresh_row;
    next_refresh_pulse  = 1'b0;
    next_last_bank      = last_bank;
    next_illegal_cmd    = |bank_illegal;
    next_mode_bank_bits = mode_bank_bits;
    next_mode_opcode    = mode_opcode;
    next_last_cmd_pins  = cmd_pins;
    unique case (dev_state)
      sdrbs_pkg::DEV_NORMAL: begin
        if (sp.cke && (cmd == sdrbs_pkg::SDRBS_READ || cmd == sdrbs_pkg::SDRBS_WRITE)) begin
          next_last_bank = bank_sel;
        end
        if (cmd == sdrbs_pkg::SDRBS_REFRESH || cmd == sdrbs_pkg::SDRBS_MODE_LOAD) begin
          if (!(&bank_idle)) begin
            next_illegal_cmd = 1'b1;
          end else if (cmd == sdrbs_pkg::SDRBS_MODE_LOAD) begin
            next_dev_state      = sdrbs_pkg::DEV_MODE_LOAD;
            next_busy_cnt       = sdrbs_pkg::MODE_LOAD_CYC;
            next_mode_bank_bits = bank_sel;
            next_mode_opcode    = sp.addr;
          end else if (!sp.cke) begin
            if (AUTOMOTIVE) begin
              next_illegal_cmd = 1'b1;
            end else begin
              // the first internal refresh happens on entry
              next_dev_state     = sdrbs_pkg::DEV_SELF_REFRESH;
              next_sr_timer      = sdrbs_pkg::SR_INTERVAL_CYC;
              next_refresh_pulse = 1'b1;
              next_refresh_row   = refresh_row + 1'b1;
            end
          end else begin
            next_dev_state     = sdrbs_pkg::DEV_REFRESHING;
            next_busy_cnt      = sdrbs_pkg::REFRESH_CYC;
            next_refresh_pulse = 1'b1;
            next_refresh_row   = refresh_row + 1'b1;
          end
        end else if (pre_all) begin
          next_dev_state = sdrbs_pkg::DEV_PRECHARGE_ALL;
          next_busy_cnt  = sdrbs_pkg::PRECHARGE_CYC;
        end
      end
      sdrbs_pkg::DEV_REFRESHING, sdrbs_pkg::DEV_MODE_LOAD,
      sdrbs_pkg::DEV_PRECHARGE_ALL, sdrbs_pkg::DEV_SR_EXIT: begin
        if (!sp.chip_select_n && cmd != sdrbs_pkg::SDRBS_NOP) begin
          next_illegal_cmd = 1'b1;
        end
        if (next_busy_cnt == sdrbs_pkg::CNT_ZERO) begin
          next_dev_state = sdrbs_pkg::DEV_NORMAL;
        end
      end
      sdrbs_pkg::DEV_SELF_REFRESH: begin
        // every input but clock-enable is ignored here
        if (sp.cke) begin
          next_dev_state = sdrbs_pkg::DEV_SR_EXIT;
          next_busy_cnt  = sdrbs_pkg::SR_EXIT_CYC;
        end else if (sr_timer == sdrbs_pkg::CNT_ZERO) begin
          next_sr_timer      = sdrbs_pkg::SR_INTERVAL_CYC;
          next_refresh_pulse = 1'b1;
          next_refresh_row   = refresh_row + 1'b1;
        end else begin
          next_sr_timer = sr_timer - 1'b1;
        end
      end
      default: begin
        next_dev_state = sdrbs_pkg::DEV_NORMAL;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      dev_state      <= sdrbs_pkg::DEV_NORMAL;
      busy_cnt       <= sdrbs_pkg::CNT_ZERO;
      sr_timer       <= sdrbs_pkg::CNT_ZERO;
      refresh_row    <= sdrbs_pkg::ROW_RESET;
      refresh_pulse  <= 1'b0;
      last_bank      <= 2'h0;
      illegal_cmd    <= 1'b0;
      mode_bank_bits <= 2'h0;
      mode_opcode    <= 13'h0000;
      last_cmd_pins  <= 5'h08;
    end else begin
      dev_state      <= next_dev_state;
      busy_cnt       <= next_busy_cnt;
      sr_timer       <= next_sr_timer;
      refresh_row    <= next_refresh_row;
      refresh_pulse  <= next_refresh_pulse;
      last_bank      <= next_last_bank;
      illegal_cmd    <= next_illegal_cmd;
      mode_bank_bits <= next_mode_bank_bits;
      mode_opcode    <= next_mode_opcode;
      last_cmd_pins  <= next_last_cmd_pins;
    end
  end
endmodule : sdrbs_top

/* tb/sdrbs_ctrl_model.sv */
// sdrbs_ctrl_model: controller side of the command pins, one command per request.
// assumes the bench raises go for one core_clk cycle per command.
`timescale 1ns/1ns
module sdrbs_ctrl_model (
  // clock
  input  wire logic                 core_clk,
  // request: code is {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n}
  input  wire logic                 go,
  input  wire logic [3:0]           code,
  input  wire logic [1:0]           bank,
  input  wire logic [12:0]          addr,
  input  wire logic                 cke,
  // device pins
  output sdrbs_pkg::sdrbs_pins_type pins
);
  logic hold = 1'b0;
  initial pins = {1'b1, 4'h7, 15'h0000};
  always @(posedge core_clk) begin
    // a command stands two cycles: the device filter drops a one-cycle value
    hold <= go;
    if (go) begin
      pins <= {cke, code, bank, addr};
    end else if (!hold) begin
      // idle fill is a nop; unused lines flip so a stale value is never trusted
      pins <= {cke, 4'h7, ~pins.bank_select_high, ~pins.bank_select_low, ~pins.addr};
    end
  end
endmodule : sdrbs_ctrl_model

/* tb/sdrbs_top_checker.sv */
// sdrbs_top_checker: timing relations on the ports of sdrbs_top.
// assumes one core_clk domain and the synchronous reset srst.
`timescale 1ns/1ns
module sdrbs_top_checker (
  // clock and reset
  input wire logic                            core_clk,
  input wire logic                            srst,
  // pins and status
  input wire sdrbs_pkg::sdrbs_pins_type       pins,
  input wire sdrbs_pkg::sdrbs_bank_state_type bank_state [sdrbs_pkg::NUM_BANKS],
  input wire sdrbs_pkg::sdrbs_dev_state_type  dev_state,
  input wire logic                            all_idle,
  input wire logic                            self_refresh_active,
  input wire logic                            refresh_pulse,
  input wire logic [sdrbs_pkg::ROW_W-1:0]     refresh_row
);
  logic [11:0] sr_gap;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // cycles since the last refresh while self-timed; rests at zero otherwise
  always_ff @(posedge core_clk) begin
    sr_gap <= (srst || refresh_pulse || !self_refresh_active) ? 12'h000 : sr_gap + 12'h001;
  end
  sequence s_ref_busy;
    (dev_state == sdrbs_pkg::DEV_REFRESHING) [*8];
  endsequence
  property p_row_step;
    refresh_pulse |-> refresh_row == $past(refresh_row) + 13'h0001;
  endproperty
  a_row_step: assert property (p_row_step) else $error("refresh row did not advance by one");
  property p_ref_busy;
    $rose(dev_state == sdrbs_pkg::DEV_REFRESHING) |-> s_ref_busy ##[1:3] dev_state == sdrbs_pkg::DEV_NORMAL;
  endproperty
  a_ref_busy: assert property (p_ref_busy) else $error("refresh busy period wrong");
  property p_ref_idle;
    $rose(dev_state == sdrbs_pkg::DEV_REFRESHING) |-> $past(all_idle);
  endproperty
  a_ref_idle: assert property (p_ref_idle) else $error("refresh taken with a bank busy");
  property p_mode_idle;
    $rose(dev_state == sdrbs_pkg::DEV_MODE_LOAD) |-> $past(all_idle);
  endproperty
  a_mode_idle: assert property (p_mode_idle) else $error("mode load taken with a bank busy");
  property p_sr_hold;
    (!pins.cke) [*4] ##0 self_refresh_active |=> self_refresh_active;
  endproperty
  a_sr_hold: assert property (p_sr_hold) else $error("self refresh left with clock enable low");
  property p_sr_exit;
    $fell(self_refresh_active) |-> (dev_state == sdrbs_pkg::DEV_SR_EXIT) [*2];
  endproperty
  a_sr_exit: assert property (p_sr_exit) else $error("exit wait shorter than two cycles");
  property p_sr_timer;
    sr_gap <= 12'h3d8;
  endproperty
  a_sr_timer: assert property (p_sr_timer) else $error("no self-timed refresh in time");
  property p_act;
    $rose(bank_state[1] == sdrbs_pkg::BANK_ACTIVATING) |-> ##3 bank_state[1] == sdrbs_pkg::BANK_ROW_ACTIVE;
  endproperty
  a_act: assert property (p_act) else $error("activation length wrong");
endmodule : sdrbs_top_checker
bind sdrbs_top sdrbs_top_checker u_chk (
  .core_clk(core_clk), .srst(srst), .pins(pins), .bank_state(bank_state), .dev_state(dev_state),
  .all_idle(all_idle), .self_refresh_active(self_refresh_active), .refresh_pulse(refresh_pulse),
  .refresh_row(refresh_row)
);

/* tb/tb_sdrbs_top.sv */
// tb_sdrbs_top: directed scenarios for sdrbs_top through the controller model.
// assumes the model adds one register stage ahead of the device pins.
`timescale 1ns/1ns
module tb_sdrbs_top;
  localparam logic [3:0] C_NOP = 4'h7, C_ACT = 4'h3, C_REF = 4'h1, C_MRS = 4'h0;
  localparam logic [3:0] C_PRE = 4'h2, C_RD = 4'h5, C_WR = 4'h4, C_BST = 4'h6;
  logic                            core_clk = 1'b0;
  logic                            srst = 1'b1;
  logic                            go = 1'b0;
  logic                            cke = 1'b1;
  logic [3:0]                      code = 4'h7;
  logic [1:0]                      bank = 2'h0;
  logic [12:0]                     addr = 13'h0000;
  logic [12:0]                     refresh_row, mode_opcode;
  logic [1:0]                      mode_bank_bits;
  logic                            all_idle, sr_act, ref_pulse, illegal_cmd;
  sdrbs_pkg::sdrbs_pins_type       pins;
  sdrbs_pkg::sdrbs_bank_state_type bank_state [sdrbs_pkg::NUM_BANKS];
  sdrbs_pkg::sdrbs_dev_state_type  dev_state;
  int                              error_cnt = 0, n_compared = 0, n_ref = 0, n_ill = 0, cyc = 0;
  sdrbs_ctrl_model u_ctrl (.core_clk(core_clk), .go(go), .code(code), .bank(bank), .addr(addr), .cke(cke),
    .pins(pins));
  sdrbs_top dut (.core_clk(core_clk), .srst(srst), .pins(pins), .bank_state(bank_state), .dev_state(dev_state),
    .all_idle(all_idle), .self_refresh_active(sr_act), .refresh_pulse(ref_pulse), .refresh_row(refresh_row),
    .mode_bank_bits(mode_bank_bits), .mode_opcode(mode_opcode), .illegal_cmd(illegal_cmd));
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  // pulses last one cycle, so they are counted here rather than polled
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (ref_pulse === 1'b1) n_ref <= n_ref + 1;
    if (illegal_cmd === 1'b1) n_ill <= n_ill + 1;
    if (cyc == 5000) begin
      error_cnt = error_cnt + 1;
      wrap_up();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  // effect lands six edges after go: model stage, four filter stages, state; counts one later
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a, input int w,
                     input logic k = 1'b1);
    @(posedge core_clk);
    {go, code, bank, addr, cke} <= {1'b1, c, b, a, k};
    @(posedge core_clk);
    go <= 1'b0;
    step(w);
  endtask : cmd
  task automatic t_bank_flow;
    int i0;
    i0 = n_ill;
    cmd(C_ACT, 2'h1, 13'h0155, 5);
    chk(16'(bank_state[1]), 16'(sdrbs_pkg::BANK_ACTIVATING));
    step(3);
    chk(16'(bank_state[1]), 16'(sdrbs_pkg::BANK_ROW_ACTIVE));
    cmd(C_RD, 2'h1, 13'h0000, 0);
    cmd(C_WR, 2'h1, 13'h0000, 0);
    cmd(C_PRE, 2'h1, 13'h0000, 5);
    chk(16'(bank_state[1]), 16'(sdrbs_pkg::BANK_PRECHARGING));
    step(3);
    chk(16'(bank_state[1]), 16'(sdrbs_pkg::BANK_IDLE));
    cmd(C_PRE, 2'h2, 13'h0000, 7);
    chk(16'(bank_state[2]), 16'(sdrbs_pkg::BANK_IDLE));
    chk(16'(n_ill - i0), 16'h0000);
  endtask : t_bank_flow
  task automatic t_stop;
    cmd(C_ACT, 2'h0, 13'h0000, 5);
    step(3);
    cmd(C_RD, 2'h0, 13'h0000, 0);
    cmd(C_BST, 2'h3, 13'h0000, 5);
    chk(16'(bank_state[0]), 16'(sdrbs_pkg::BANK_ROW_ACTIVE));
    cmd(C_WR, 2'h0, 13'h0400, 5);
    chk(16'(bank_state[0]), 16'(sdrbs_pkg::BANK_WRITE_AP));
    step(7);
    chk(16'(bank_state[0]), 16'(sdrbs_pkg::BANK_IDLE));
  endtask : t_stop
  task automatic t_refresh;
    int          i0, r0;
    logic [12:0] row0;
    cmd(C_ACT, 2'h3, 13'h0000, 5);
    step(3);
    i0 = n_ill;
    r0 = n_ref;
    cmd(C_REF, 2'h0, 13'h0000, 6);
    chk(16'(n_ill - i0), 16'h0001);
    chk(16'(n_ref - r0), 16'h0000);
    cmd(C_PRE, 2'h0, 13'h0400, 5);
    chk(16'(dev_state), 16'(sdrbs_pkg::DEV_PRECHARGE_ALL));
    step(4);
    chk(16'(all_idle), 16'h0001);
    row0 = refresh_row;
    cmd(C_REF, 2'h3, 13'h1fff, 0);
    cmd(C_ACT, 2'h1, 13'h0000, 6);
    chk(16'(dev_state), 16'(sdrbs_pkg::DEV_REFRESHING));
    chk(16'(refresh_row), 16'(row0 + 13'h0001));
    chk(16'(n_ill - i0), 16'h0002);
    step(8);
    chk(16'(dev_state), 16'(sdrbs_pkg::DEV_NORMAL));
  endtask : t_refresh
  task automatic t_mode;
    cmd(4'hb, 2'h0, 13'h0000, 5);
    chk(16'(bank_state[0]), 16'(sdrbs_pkg::BANK_IDLE));
    cmd(C_MRS, 2'h2, 13'h0032, 5);
    chk(16'(dev_state), 16'(sdrbs_pkg::DEV_MODE_LOAD));
    chk(16'({mode_bank_bits, mode_opcode}), 16'h4032);
  endtask : t_mode
  task automatic t_self;
    int r0, i0;
    r0 = n_ref;
    i0 = n_ill;
    cmd(C_REF, 2'h0, 13'h0000, 5, 1'b0);
    chk(16'(dev_state), 16'(sdrbs_pkg::DEV_SELF_REFRESH));
    cmd(C_ACT, 2'h1, 13'h0000, 7, 1'b0);
    chk(16'({n_ill - i0, bank_state[1]}), 16'(sdrbs_pkg::BANK_IDLE));
    step(980);
    chk(16'(n_ref - r0), 16'h0002);
    cmd(C_NOP, 2'h0, 13'h0000, 5);
    chk(16'(dev_state), 16'(sdrbs_pkg::DEV_SR_EXIT));
    step(9);
    chk(16'(dev_state), 16'(sdrbs_pkg::DEV_NORMAL));
    cmd(C_REF, 2'h0, 13'h0000, 6);
    chk(16'(n_ref - r0), 16'h0003);
  endtask : t_self
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    step(1);
    chk(16'(all_idle), 16'h0001);
    t_bank_flow();
    t_stop();
    t_refresh();
    t_mode();
    t_self();
    wrap_up();
  end
endmodule : tb_sdrbs_top
